// ===== rtl/bgr_conv.sv
// Conversion sequencer: voltage, current, temperature, then sleep
`timescale 1ns/1ps
`default_nettype none
`include "bgr_defines.svh"
module bgr_conv #(
  parameter int unsigned SCAN_CYCLES = `BGR_SCAN_S * `BGR_CLK_HZ
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Control
  input  wire logic [1:0]        mode_i,
  input  wire logic              trig_i,
  // Converter
  input  wire logic              done_i,
  input  wire logic [15:0]       data_i,
  output logic                   start_o,
  output logic                   busy_o,
  output bgr_pkg::bgr_cst_t      sel_o,
  output bgr_pkg::bgr_res_t      res_o
);
  import bgr_pkg::*;
  localparam logic [31:0] LAST = 32'(SCAN_CYCLES - 1);
  bgr_cnv_t s_reg;
  bgr_cnv_t s_next;
  logic     go;

  always_comb begin
    s_next = s_reg;
    s_next.start = 1'b0;
    s_next.res.vld = 1'b0;
    go = 1'b0;
    if (trig_i) begin
      s_next.armed = (mode_i == `BGR_MODE_AUTO) || (mode_i == `BGR_MODE_SCAN);
      s_next.cnt = LAST;
    end else if (s_reg.armed && mode_i == `BGR_MODE_SCAN) begin
      s_next.cnt = (s_reg.cnt == 32'h0) ? LAST : s_reg.cnt - 32'h1;
    end
    case (s_reg.st)
      CS_IDLE: begin
        go = (trig_i && mode_i != `BGR_MODE_SLEEP) ||
             (s_reg.armed && mode_i == `BGR_MODE_AUTO) ||
             (s_reg.armed && mode_i == `BGR_MODE_SCAN &&
              s_reg.cnt == 32'h0);
        if (go) begin
          s_next.st = CS_VOLT;
          s_next.start = 1'b1;
        end
      end
      CS_VOLT, CS_CURR, CS_TEMP: begin
        if (done_i) begin
          s_next.res = '{vld: 1'b1, sel: s_reg.st, data: data_i};
          s_next.start = (s_reg.st != CS_TEMP);
          s_next.st = (s_reg.st == CS_VOLT) ? CS_CURR :
                      (s_reg.st == CS_CURR) ? CS_TEMP : CS_IDLE;
        end
      end
      default: s_next.st = CS_IDLE;
    endcase
    s_next.busy = (s_next.st != CS_IDLE);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign start_o = s_reg.start;
  assign busy_o  = s_reg.busy;
  assign sel_o   = s_reg.st;
  assign res_o   = s_reg.res;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_no_self_start: assert property (s_reg.st == CS_IDLE && !trig_i &&
                                    !s_reg.armed |=> !start_o)
    else $error("conversion started without a control write");
  a_sleep_after: assert property (s_reg.st == CS_TEMP && done_i
                                  |=> !busy_o && res_o.vld)
    else $error("converter not asleep after last result");
endmodule // bgr_conv
`default_nettype wire

// ===== rtl/bgr_defines.svh
// Constants of the gauge register and alert core
`ifndef BGR_DEFINES_SVH
`define BGR_DEFINES_SVH
`define BGR_CLK_HZ     40000000
`define BGR_SCAN_S     10
`define BGR_A_STAT     8'h00
`define BGR_A_CTL      8'h01
`define BGR_A_ACR_H    8'h02
`define BGR_A_ACR_L    8'h03
`define BGR_A_CHI_H    8'h04
`define BGR_A_CHI_L    8'h05
`define BGR_A_CLO_H    8'h06
`define BGR_A_CLO_L    8'h07
`define BGR_A_VRES_H   8'h08
`define BGR_A_VRES_L   8'h09
`define BGR_A_VHI_H    8'h0A
`define BGR_A_VHI_L    8'h0B
`define BGR_A_VLO_H    8'h0C
`define BGR_A_VLO_L    8'h0D
`define BGR_A_IRES_H   8'h0E
`define BGR_A_IRES_L   8'h0F
`define BGR_A_IHI_H    8'h10
`define BGR_A_IHI_L    8'h11
`define BGR_A_ILO_H    8'h12
`define BGR_A_ILO_L    8'h13
`define BGR_A_TRES_H   8'h14
`define BGR_A_TRES_L   8'h15
`define BGR_A_THI      8'h16
`define BGR_A_TLO      8'h17
`define BGR_F_SUPPLY_LOW_LOCKOUT     0
`define BGR_F_VOLT     1
`define BGR_F_CLO      2
`define BGR_F_CHI      3
`define BGR_F_TEMP     4
`define BGR_F_OVF      5
`define BGR_F_CURR     6
`define BGR_CTL_RST    8'h3C
`define BGR_ACR_RST    16'h7FFF
`define BGR_HI16       16'hFFFF
`define BGR_LO16       16'h0000
`define BGR_HI8        8'hFF
`define BGR_MODE_AUTO  2'h3
`define BGR_MODE_SCAN  2'h2
`define BGR_MODE_SLEEP 2'h0
`define BGR_M_MAX      13'h1000
`define BGR_M_CODE_MAX 3'h6
`endif

// ===== rtl/bgr_pkg.sv
// Types of the gauge register and alert core
package bgr_pkg;
  typedef struct packed {
    logic [1:0] mode;
    logic [2:0] presc;
    logic       alert_en;
    logic       cc_en;
    logic       shdn;
  } bgr_ctl_t;
  typedef enum logic [1:0] {
    CS_IDLE = 2'b00,
    CS_VOLT = 2'b01,
    CS_CURR = 2'b11,
    CS_TEMP = 2'b10
  } bgr_cst_t;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [7:0]  wdata;
  } bgr_req_t;
  typedef struct packed {
    logic        vld;
    bgr_cst_t    sel;
    logic [15:0] data;
  } bgr_res_t;
  typedef struct packed {
    logic [11:0] cnt;
    logic        inc;
    logic        dec;
  } bgr_pre_t;
  typedef struct packed {
    bgr_cst_t    st;
    logic        start;
    logic        busy;
    logic        armed;
    logic [31:0] cnt;
    bgr_res_t    res;
  } bgr_cnv_t;
endpackage : bgr_pkg

// ===== rtl/bgr_presc.sv
// Coulomb prescaler: divides integrator steps by M
`timescale 1ns/1ps
`default_nettype none
`include "bgr_defines.svh"
module bgr_presc (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Integrator steps and setup
  input  wire logic       up_i,
  input  wire logic       dn_i,
  input  wire logic       run_i,
  input  wire logic [2:0] code_i,
  // Charge count steps
  output logic            inc_o,
  output logic            dec_o
);
  import bgr_pkg::*;
  bgr_pre_t    s_reg;
  bgr_pre_t    s_next;
  logic [12:0] m;
  logic [11:0] lim;

  always_comb begin
    s_next = s_reg;
    s_next.inc = 1'b0;
    s_next.dec = 1'b0;
    m = (code_i >= `BGR_M_CODE_MAX) ? `BGR_M_MAX
                                    : 13'(13'h1 << {code_i, 1'b0});
    lim = 12'(m - 13'h1);
    if (run_i && up_i && !dn_i) begin
      if (s_reg.cnt >= lim) begin
        s_next.cnt = 12'h000;
        s_next.inc = 1'b1;
      end else begin
        s_next.cnt = s_reg.cnt + 12'h001;
      end
    end else if (run_i && dn_i && !up_i) begin
      if (s_reg.cnt == 12'h000) begin
        s_next.cnt = lim;
        s_next.dec = 1'b1;
      end else begin
        s_next.cnt = (s_reg.cnt > lim) ? lim : s_reg.cnt - 12'h001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign inc_o = s_reg.inc;
  assign dec_o = s_reg.dec;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_stop_supply_low_lockout: assert property (!run_i |=> !inc_o && !dec_o)
    else $error("charge step while integration stopped");
  a_presc_one: assert property (code_i == 3'h0 && run_i && up_i && !dn_i
                                |=> inc_o)
    else $error("prescale by one did not step");
endmodule // bgr_presc
`default_nettype wire

// ===== rtl/bgr_top.sv
// Register bank, charge bookkeeping and alert pin of the gauge core
//----------------------------------------------------------------------
// Behaviour
// - Prescale integrator steps by M, 1 to 4096
// - Prescaler overflow adds one, underflow subtracts one
// - Charge count readable by the host
// - Conversions start only after a control write
// - Scan mode converts all three every 10 s
// - Store each result, then converter sleeps
// - Reset: defaults, counter runs, converter off
// - Reset: charge 7FFFh, lows 0000h, highs FFFFh
// - Reset: alert enabled, M 4096, control 3Ch
// - Quantities are 16 bits in byte pairs
// - Limit crossed sets flag, alert pulls pin low
// - Results checked: current A6, temp A4, volt A1
// - Charge step checked: high A3, low A2
// - Charge wrap sets A5 and keeps counting
// - Supply low: flag A0, hold count, resume
// - Status read clears all bits, may reset
// - Control register is eight bits wide
// - Bits 7:6 pick auto, scan, manual, sleep
// - Bits 2:1 pick alert, charge done, off
// - Charge done low forces count to FFFFh
// - Alert stays low until alert response done
//----------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "bgr_defines.svh"
module bgr_top #(
  parameter int unsigned SCAN_CYCLES = `BGR_SCAN_S * `BGR_CLK_HZ
) (
  // Clock and reset
  input  wire logic              CLK_I,
  input  wire logic              RST_I,
  // Register port from the serial interface
  input  wire bgr_pkg::bgr_req_t REG_REQ_I,
  input  wire logic              ALERT_RESPONSE_DONE_I,
  output var  logic [7:0]        REG_RDATA_O,
  // Analog side
  input  wire logic              INT_UP_I,
  input  wire logic              INT_DN_I,
  input  wire logic              SUPPLY_LOW_LOCKOUT_I,
  output var  logic              SHUTDOWN_O,
  // Converter
  input  wire logic              CONV_DONE_I,
  input  wire logic [15:0]       CONV_DATA_I,
  output var  logic              CONV_START_O,
  output var  logic              ADC_ON_O,
  output bgr_pkg::bgr_cst_t      CONV_SEL_O,
  // Alert or charge done pin, open drain
  input  wire logic              ALERT_OR_CHARGE_DONE_PIN_I,
  output var  logic              ALERT_OR_CHARGE_DONE_PIN_O,
  output var  logic              ALERT_OR_CHARGE_DONE_PIN_OE_O
);
  import bgr_pkg::*;

  typedef struct packed {
    logic        up_s1, up_s2, dn_s1, dn_s2;
    logic        uv_s1, uv_s2, pin_s1, pin_s2;
    bgr_ctl_t    ctl;
    logic [15:0] accumulated_charge_count, chi, clo, vhi, vlo, ihi, ilo;
    logic [15:0] vres, ires, tres;
    logic [7:0]  thi, tlo;
    logic [6:0]  flags;
    logic        alert;
    logic [1:0]  alert_d;
    logic        pstep;
    logic        trig;
    logic [7:0]  rdata;
  } bgr_st_t;

  bgr_st_t     s_reg;
  bgr_st_t     s_next;
  logic        pre_inc;
  logic        pre_dec;
  bgr_res_t    res;
  logic [15:0] acr_nx;
  logic        step;
  logic        cc_force;
  logic        acr_wr;
  logic        stat_rd;
  logic [6:0]  fl;

  //--------------------------------------------------------------------
  // Prescaler and converter sequencer
  //--------------------------------------------------------------------
  bgr_presc u_presc (
    .clk_i  (CLK_I),
    .rst_i  (RST_I),
    .up_i   (s_reg.up_s2),
    .dn_i   (s_reg.dn_s2),
    .run_i  (!s_reg.ctl.shdn && !s_reg.uv_s2),
    .code_i (s_reg.ctl.presc),
    .inc_o  (pre_inc),
    .dec_o  (pre_dec)
  );

  bgr_conv #(
    .SCAN_CYCLES (SCAN_CYCLES)
  ) u_conv (
    .clk_i   (CLK_I),
    .rst_i   (RST_I),
    .mode_i  (s_reg.ctl.mode),
    .trig_i  (s_reg.trig),
    .done_i  (CONV_DONE_I),
    .data_i  (CONV_DATA_I),
    .start_o (CONV_START_O),
    .busy_o  (ADC_ON_O),
    .sel_o   (CONV_SEL_O),
    .res_o   (res)
  );

  //--------------------------------------------------------------------
  // Next state
  //--------------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.trig = 1'b0;
    fl = 7'h00;
    step = s_reg.pstep;
    acr_nx = s_reg.accumulated_charge_count;
    s_next.up_s1 = INT_UP_I;
    s_next.up_s2 = s_reg.up_s1;
    s_next.dn_s1 = INT_DN_I;
    s_next.dn_s2 = s_reg.dn_s1;
    s_next.uv_s1 = SUPPLY_LOW_LOCKOUT_I;
    s_next.uv_s2 = s_reg.uv_s1;
    s_next.pin_s1 = ALERT_OR_CHARGE_DONE_PIN_I;
    s_next.pin_s2 = s_reg.pin_s1;
    s_next.alert_d = {s_reg.alert_d[0], s_reg.alert};
    // Integrator step as the prescaler sees it; limits are checked on each
    s_next.pstep = !s_reg.ctl.shdn && !s_reg.uv_s2 &&
                   (s_reg.up_s2 ^ s_reg.dn_s2);
    acr_wr = REG_REQ_I.wr && (REG_REQ_I.addr == `BGR_A_ACR_H ||
                              REG_REQ_I.addr == `BGR_A_ACR_L);
    stat_rd = REG_REQ_I.rd && REG_REQ_I.addr == `BGR_A_STAT;

    // Charge count steps and wrap
    if (pre_inc) begin
      acr_nx = s_reg.accumulated_charge_count + 16'h0001;
      step = 1'b1;
      if (s_reg.accumulated_charge_count == `BGR_HI16) begin
        fl[`BGR_F_OVF] = 1'b1;
      end
    end else if (pre_dec) begin
      acr_nx = s_reg.accumulated_charge_count - 16'h0001;
      step = 1'b1;
      if (s_reg.accumulated_charge_count == `BGR_LO16) begin
        fl[`BGR_F_OVF] = 1'b1;
      end
    end
    if (step) begin
      if (acr_nx > s_reg.chi) begin
        fl[`BGR_F_CHI] = 1'b1;
      end
      if (acr_nx < s_reg.clo) begin
        fl[`BGR_F_CLO] = 1'b1;
      end
    end
    // Charge done input; ignored while our own pull-down may still sit
    // in the pin synchroniser
    cc_force = s_reg.ctl.cc_en && !s_reg.pin_s2 && !s_reg.alert &&
               s_reg.alert_d == 2'h0;
    if (cc_force) begin
      acr_nx = `BGR_HI16;
    end
    s_next.accumulated_charge_count = acr_nx;

    // Conversion results
    if (res.vld) begin
      case (res.sel)
        CS_VOLT: begin
          s_next.vres = res.data;
          if (res.data > s_reg.vhi || res.data < s_reg.vlo) begin
            fl[`BGR_F_VOLT] = 1'b1;
          end
        end
        CS_CURR: begin
          s_next.ires = res.data;
          if (res.data > s_reg.ihi || res.data < s_reg.ilo) begin
            fl[`BGR_F_CURR] = 1'b1;
          end
        end
        CS_TEMP: begin
          s_next.tres = res.data;
          if (res.data[15:8] > s_reg.thi || res.data[15:8] < s_reg.tlo) begin
            fl[`BGR_F_TEMP] = 1'b1;
          end
        end
        default: ;
      endcase
    end
    if (s_reg.uv_s2) begin
      fl[`BGR_F_SUPPLY_LOW_LOCKOUT] = 1'b1;
    end

    // Host writes; result and status addresses keep their values
    if (REG_REQ_I.wr) begin
      case (REG_REQ_I.addr)
        `BGR_A_CTL: begin
          s_next.ctl = bgr_ctl_t'(REG_REQ_I.wdata);
          s_next.trig = 1'b1;
        end
        `BGR_A_ACR_H: s_next.accumulated_charge_count[15:8] = REG_REQ_I.wdata;
        `BGR_A_ACR_L: s_next.accumulated_charge_count[7:0] = REG_REQ_I.wdata;
        `BGR_A_CHI_H: s_next.chi[15:8] = REG_REQ_I.wdata;
        `BGR_A_CHI_L: s_next.chi[7:0] = REG_REQ_I.wdata;
        `BGR_A_CLO_H: s_next.clo[15:8] = REG_REQ_I.wdata;
        `BGR_A_CLO_L: s_next.clo[7:0] = REG_REQ_I.wdata;
        `BGR_A_VHI_H: s_next.vhi[15:8] = REG_REQ_I.wdata;
        `BGR_A_VHI_L: s_next.vhi[7:0] = REG_REQ_I.wdata;
        `BGR_A_VLO_H: s_next.vlo[15:8] = REG_REQ_I.wdata;
        `BGR_A_VLO_L: s_next.vlo[7:0] = REG_REQ_I.wdata;
        `BGR_A_IHI_H: s_next.ihi[15:8] = REG_REQ_I.wdata;
        `BGR_A_IHI_L: s_next.ihi[7:0] = REG_REQ_I.wdata;
        `BGR_A_ILO_H: s_next.ilo[15:8] = REG_REQ_I.wdata;
        `BGR_A_ILO_L: s_next.ilo[7:0] = REG_REQ_I.wdata;
        `BGR_A_THI:   s_next.thi = REG_REQ_I.wdata;
        `BGR_A_TLO:   s_next.tlo = REG_REQ_I.wdata;
        default: ;
      endcase
    end

    // Host reads; data appear one cycle after the request
    if (REG_REQ_I.rd) begin
      case (REG_REQ_I.addr)
        `BGR_A_STAT:   s_next.rdata = {1'b0, s_reg.flags};
        `BGR_A_CTL:    s_next.rdata = s_reg.ctl;
        `BGR_A_ACR_H:  s_next.rdata = s_reg.accumulated_charge_count[15:8];
        `BGR_A_ACR_L:  s_next.rdata = s_reg.accumulated_charge_count[7:0];
        `BGR_A_CHI_H:  s_next.rdata = s_reg.chi[15:8];
        `BGR_A_CHI_L:  s_next.rdata = s_reg.chi[7:0];
        `BGR_A_CLO_H:  s_next.rdata = s_reg.clo[15:8];
        `BGR_A_CLO_L:  s_next.rdata = s_reg.clo[7:0];
        `BGR_A_VRES_H: s_next.rdata = s_reg.vres[15:8];
        `BGR_A_VRES_L: s_next.rdata = s_reg.vres[7:0];
        `BGR_A_VHI_H:  s_next.rdata = s_reg.vhi[15:8];
        `BGR_A_VHI_L:  s_next.rdata = s_reg.vhi[7:0];
        `BGR_A_VLO_H:  s_next.rdata = s_reg.vlo[15:8];
        `BGR_A_VLO_L:  s_next.rdata = s_reg.vlo[7:0];
        `BGR_A_IRES_H: s_next.rdata = s_reg.ires[15:8];
        `BGR_A_IRES_L: s_next.rdata = s_reg.ires[7:0];
        `BGR_A_IHI_H:  s_next.rdata = s_reg.ihi[15:8];
        `BGR_A_IHI_L:  s_next.rdata = s_reg.ihi[7:0];
        `BGR_A_ILO_H:  s_next.rdata = s_reg.ilo[15:8];
        `BGR_A_ILO_L:  s_next.rdata = s_reg.ilo[7:0];
        `BGR_A_TRES_H: s_next.rdata = s_reg.tres[15:8];
        `BGR_A_TRES_L: s_next.rdata = s_reg.tres[7:0];
        `BGR_A_THI:    s_next.rdata = s_reg.thi;
        `BGR_A_TLO:    s_next.rdata = s_reg.tlo;
        default:       s_next.rdata = 8'h00;
      endcase
    end

    // Status clears on read; a new event in that cycle survives
    if (stat_rd) begin
      s_next.flags = fl;
    end else begin
      s_next.flags = s_reg.flags | fl;
    end

    // Alert latch: held through mode changes until the host answers
    if (s_reg.ctl.alert_en && |fl) begin
      s_next.alert = 1'b1;
    end else if (ALERT_RESPONSE_DONE_I) begin
      s_next.alert = 1'b0;
    end
  end

  //--------------------------------------------------------------------
  // State register
  //--------------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      s_reg <= '0;
      s_reg.pin_s1 <= 1'b1;
      s_reg.pin_s2 <= 1'b1;
      s_reg.ctl <= bgr_ctl_t'(`BGR_CTL_RST);
      s_reg.accumulated_charge_count <= `BGR_ACR_RST;
      s_reg.chi <= `BGR_HI16;
      s_reg.vhi <= `BGR_HI16;
      s_reg.ihi <= `BGR_HI16;
      s_reg.thi <= `BGR_HI8;
    end else begin
      s_reg <= s_next;
    end
  end

  assign REG_RDATA_O = s_reg.rdata;
  assign SHUTDOWN_O = s_reg.ctl.shdn;
  assign ALERT_OR_CHARGE_DONE_PIN_O = 1'b0;
  assign ALERT_OR_CHARGE_DONE_PIN_OE_O = s_reg.alert;

  //--------------------------------------------------------------------
  // Checks
  //--------------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  a_reset_vals: assert property ($fell(RST_I)
    |-> s_reg.accumulated_charge_count == `BGR_ACR_RST && s_reg.ctl == `BGR_CTL_RST
    && s_reg.clo == `BGR_LO16)
    else $error("reset defaults wrong");
  a_acr_inc: assert property (pre_inc && !cc_force && !acr_wr
    |=> s_reg.accumulated_charge_count == $past(s_reg.accumulated_charge_count) + 16'h0001)
    else $error("charge count did not step up by one");
  a_acr_wrap: assert property (pre_inc && s_reg.accumulated_charge_count == `BGR_HI16
    && !cc_force && !acr_wr
    |=> s_reg.accumulated_charge_count == `BGR_LO16 && s_reg.flags[`BGR_F_OVF])
    else $error("wrap not flagged");
  a_chg_high: assert property (step && !cc_force && acr_nx > s_reg.chi
    |=> s_reg.flags[`BGR_F_CHI])
    else $error("charge high limit missed");
  a_chg_low: assert property (step && !cc_force && acr_nx < s_reg.clo
    |=> s_reg.flags[`BGR_F_CLO])
    else $error("charge low limit missed");
  a_volt_high: assert property (res.vld && res.sel == CS_VOLT
    && res.data > s_reg.vhi |=> s_reg.flags[`BGR_F_VOLT])
    else $error("voltage limit missed");
  a_stat_clear: assert property (stat_rd && fl == 7'h00
    |=> s_reg.flags == 7'h00
    && REG_RDATA_O == {1'b0, $past(s_reg.flags)})
    else $error("status not cleared on read");
  a_alert_hold: assert property (ALERT_OR_CHARGE_DONE_PIN_OE_O
    && !ALERT_RESPONSE_DONE_I |=> ALERT_OR_CHARGE_DONE_PIN_OE_O)
    else $error("alert released without response");
  a_alert_set: assert property (s_reg.ctl.alert_en && |fl
    |=> ALERT_OR_CHARGE_DONE_PIN_OE_O)
    else $error("alert not driven");
  a_cc_force: assert property (cc_force && !acr_wr
    |=> s_reg.accumulated_charge_count == `BGR_HI16)
    else $error("charge done did not fill count");
  a_ro_ignore: assert property (REG_REQ_I.wr && !res.vld
    && REG_REQ_I.addr == `BGR_A_VRES_H |=> $stable(s_reg.vres))
    else $error("read-only result changed by write");
  a_supply_low_lockout_flag: assert property (s_reg.uv_s2
    |=> s_reg.flags[`BGR_F_SUPPLY_LOW_LOCKOUT])
    else $error("supply low not flagged");

  c_wrap: cover property (pre_inc && s_reg.accumulated_charge_count == `BGR_HI16);
  c_alert: cover property (ALERT_OR_CHARGE_DONE_PIN_OE_O
    ##[1:20] ALERT_RESPONSE_DONE_I);
  c_conv_set: cover property (res.vld && res.sel == CS_TEMP);
  c_scan: cover property (s_reg.ctl.mode == `BGR_MODE_SCAN
    && CONV_START_O && CONV_SEL_O == CS_VOLT);
endmodule // bgr_top
`default_nettype wire

// ===== test/bgr_conv_model.sv
// Behavioural converter answering the sequencer's start pulses
`timescale 1ns/1ps
`default_nettype none
module bgr_conv_model #(
  parameter int          DELAY = 4,
  parameter logic [15:0] VOLT  = 16'h1234,
  parameter logic [15:0] CURR  = 16'h0100,
  parameter logic [15:0] TEMP  = 16'h2000
) (
  // Clock and sequencer side
  input  wire logic              clk_i,
  input  wire logic              start_i,
  input  wire bgr_pkg::bgr_cst_t sel_i,
  // Result side
  output logic                   done_o,
  output logic [15:0]            data_o
);
  import bgr_pkg::*;
  int          cnt  = 0;
  bgr_cst_t    kind = CS_IDLE;
  logic [15:0] last = 16'h0000;
  initial done_o = 1'b0;
  initial data_o = 16'h0000;
  // Data is only valid with done; otherwise it shows garbage
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    data_o <= ~last;
    if (start_i) begin
      cnt  <= DELAY;
      kind <= sel_i;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) begin
        done_o <= 1'b1;
        data_o <= (kind == CS_VOLT) ? VOLT : (kind == CS_CURR) ? CURR : TEMP;
        last   <= (kind == CS_VOLT) ? VOLT : (kind == CS_CURR) ? CURR : TEMP;
      end
    end
  end
endmodule // bgr_conv_model
`default_nettype wire

// ===== test/tb_top.sv
// Register level testbench of the gauge core
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import bgr_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  bgr_req_t    req = '0;
  logic        ard = 1'b0;
  logic        up  = 1'b0;
  logic        dn  = 1'b0;
  logic        uv  = 1'b0;
  logic        pin_drv = 1'b1;
  logic [7:0]  rdata;
  logic        shdn, cstart, adc_on, done, oe, pin_o;
  bgr_cst_t    sel;
  logic [15:0] cdata;
  logic [7:0]  d;
  int          n;
  int          bad_count = 0;
  int          cmp_count = 0;
  logic [7:0]  rst_tab [0:23] = '{8'h00, 8'h3C, 8'h7F, 8'hFF, 8'hFF, 8'hFF,
    8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00,
    8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00};
  logic [7:0]  ro [0:6] = '{8'h00, 8'h08, 8'h09, 8'h0E, 8'h0F, 8'h14, 8'h15};
  // Open drain pin with pull-up
  wire         pin = oe ? 1'b0 : pin_drv;
  always #12.5 clk = ~clk;
  bgr_top #(.SCAN_CYCLES(200)) u_bgr_top (
    .CLK_I(clk), .RST_I(rst), .REG_REQ_I(req), .ALERT_RESPONSE_DONE_I(ard),
    .REG_RDATA_O(rdata), .INT_UP_I(up), .INT_DN_I(dn),
    .SUPPLY_LOW_LOCKOUT_I(uv), .SHUTDOWN_O(shdn), .CONV_DONE_I(done),
    .CONV_DATA_I(cdata), .CONV_START_O(cstart), .ADC_ON_O(adc_on),
    .CONV_SEL_O(sel), .ALERT_OR_CHARGE_DONE_PIN_I(pin),
    .ALERT_OR_CHARGE_DONE_PIN_O(pin_o), .ALERT_OR_CHARGE_DONE_PIN_OE_O(oe));
  bgr_conv_model #(.DELAY(4)) u_bgr_conv_model (
    .clk_i(clk), .start_i(cstart), .sel_i(sel), .done_o(done),
    .data_o(cdata));
  //--------------------------------------------------------------------
  // Access and check tasks
  //--------------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk) req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(negedge clk) req = '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk) req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk) req = '0;
    v = rdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, v});
  endtask
  task automatic rchk16(input logic [7:0] a, input logic [15:0] e);
    rchk(a, e[15:8]);
    rchk(8'(a + 8'h01), e[7:0]);
  endtask
  task automatic step(input logic u, input int k);
    repeat (k) begin
      @(negedge clk);
      up = u;
      dn = ~u;
      @(negedge clk);
      up = 1'b0;
      dn = 1'b0;
    end
    repeat (6) @(negedge clk);
  endtask
  task automatic ack;
    @(negedge clk) ard = 1'b1;
    @(negedge clk) ard = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task automatic wait_on(input logic v);
    int i;
    for (i = 0; i < 300 && adc_on !== v; i++) @(negedge clk);
    chk("adc_on level", {15'h0, v}, {15'h0, adc_on});
    if (adc_on !== v) conclude();
    repeat (3) @(negedge clk);
  endtask
  task automatic runs(input int cyc, output int k);
    logic p;
    p = adc_on;
    k = 0;
    repeat (cyc) begin
      @(negedge clk);
      if (p && !adc_on) k++;
      p = adc_on;
    end
  endtask
  initial begin
    repeat (20000) @(negedge clk);
    bad_count++;
    conclude();
  end
  //--------------------------------------------------------------------
  // Scenarios
  //--------------------------------------------------------------------
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (20) @(negedge clk);
    chk("adc_on idle", 16'h0, {15'h0, adc_on});
    for (int a = 0; a < 24; a++) rchk(8'(a), rst_tab[a]);
    rchk(8'h18, 8'h00);
    for (int i = 0; i < 7; i++) wr(ro[i], 8'hA5);
    for (int i = 0; i < 7; i++) rchk(ro[i], 8'h00);
    wr(8'h01, 8'h04);
    step(1'b1, 1);
    rchk16(8'h02, 16'h8000);
    wr(8'h01, 8'h0C);
    step(1'b1, 3);
    rchk16(8'h02, 16'h8000);
    step(1'b1, 1);
    rchk16(8'h02, 16'h8001);
    wr(8'h01, 8'h04);
    step(1'b0, 1);
    rchk16(8'h02, 16'h8000);
    wr(8'h04, 8'h80);
    wr(8'h05, 8'h00);
    step(1'b1, 1);
    rchk(8'h00, 8'h08);
    chk("alert oe", 16'h1, {15'h0, oe});
    chk("pin level", 16'h0, {15'h0, pin_o});
    rchk(8'h00, 8'h00);
    ack();
    chk("alert oe", 16'h0, {15'h0, oe});
    wr(8'h04, 8'hFF);
    wr(8'h05, 8'hFF);
    wr(8'h06, 8'h80);
    step(1'b0, 2);
    rchk(8'h00, 8'h04);
    wr(8'h06, 8'h00);
    wr(8'h02, 8'hFF);
    wr(8'h03, 8'hFF);
    rd(8'h00, d);
    step(1'b1, 1);
    rchk16(8'h02, 16'h0000);
    rchk(8'h00, 8'h20);
    step(1'b0, 1);
    rchk16(8'h02, 16'hFFFF);
    rd(8'h00, d);
    uv = 1'b1;
    step(1'b1, 2);
    rchk16(8'h02, 16'hFFFF);
    rchk(8'h00, 8'h01);
    uv = 1'b0;
    step(1'b1, 1);
    rchk16(8'h02, 16'h0000);
    wr(8'h01, 8'h05);
    chk("shutdown", 16'h1, {15'h0, shdn});
    step(1'b1, 1);
    rchk16(8'h02, 16'h0000);
    wr(8'h01, 8'h02);
    wr(8'h02, 8'h12);
    wr(8'h03, 8'h34);
    ack();
    rchk16(8'h02, 16'h1234);
    pin_drv = 1'b0;
    repeat (4) @(negedge clk);
    pin_drv = 1'b1;
    repeat (4) @(negedge clk);
    rchk16(8'h02, 16'hFFFF);
    wr(8'h0A, 8'h10);
    wr(8'h0B, 8'h00);
    wr(8'h12, 8'h20);
    wr(8'h16, 8'h10);
    wr(8'h01, 8'h04);
    rd(8'h00, d);
    wr(8'h01, 8'h44);
    wait_on(1'b1);
    wait_on(1'b0);
    rchk16(8'h08, 16'h1234);
    rchk16(8'h0E, 16'h0100);
    rchk16(8'h14, 16'h2000);
    rchk(8'h00, 8'h52);
    wr(8'h01, 8'h84);
    runs(500, n);
    chk("scan sets", 16'd3, 16'(n));
    wr(8'h01, 8'hC4);
    runs(200, n);
    chk("auto sets", 16'h1, {15'h0, n >= 3});
    wr(8'h01, 8'h04);
    wait_on(1'b0);
    runs(100, n);
    chk("sleep idle", 16'h0, {15'h0, adc_on});
    chk("sleep sets", 16'h0, 16'(n));
    conclude();
  end
endmodule // tb_top
`default_nettype wire
